/* File: shared/vcore_seq_pkg.sv */
// Constants for the core-voltage sequencer and fault latch.
// Assumes a 25 MHz ref_clk and an 8-bit linear target code.
package vcore_seq_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned MASK_US = 150;
  localparam int unsigned CLOCK_ENABLE_N_OUT_DELAY_US = 60;
  localparam int unsigned PGOOD_DELAY_MS = 5;
  localparam int unsigned MASK_CYC = MASK_US * (CLK_HZ / 1000000);
  localparam int unsigned CLOCK_ENABLE_N_OUT_DELAY_CYC = CLOCK_ENABLE_N_OUT_DELAY_US * (CLK_HZ / 1000000);
  localparam int unsigned PGOOD_DELAY_CYC = PGOOD_DELAY_MS * (CLK_HZ / 1000);
  // Full-rate slew step period and quarter-rate divide
  localparam int unsigned SLEW_STEP_CYC = 25;
  localparam int unsigned SOFT_DIV = 4;
  localparam logic [7:0] BOOT_CODE = 8'h58;
  localparam int unsigned CODE_W = 8;

  typedef enum logic [2:0] {
    ST_OFF      = 3'b000,
    ST_REF      = 3'b001,
    ST_MASK     = 3'b011,
    ST_SOFT     = 3'b010,
    ST_BOOTWAIT = 3'b110,
    ST_RUN      = 3'b111,
    ST_SHUT     = 3'b101,
    ST_DONE     = 3'b100
  } seq_state_t;

  // Gate-drive request per phase
  typedef enum logic [1:0] {
    GATE_OFF  = 2'b00,
    GATE_HIGH = 2'b01,
    GATE_LOW  = 2'b10
  } gate_req_t;
endpackage : vcore_seq_pkg

/* File: verilog/dead_time_phase.sv */
// One phase of gate drive with adaptive dead time.
// Assumes gate-off sense inputs already synchronised by the caller.
`timescale 1ns/100ps
module dead_time_phase (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      reset,
  // Request and sense
  input  wire vcore_seq_pkg::gate_req_t  request,
  input  wire logic                      highOffSense,
  input  wire logic                      lowOffSense,
  // Gate outputs
  output logic                           highGate,
  output logic                           lowGate
);
  logic highGate_reg, highGate_next;
  logic lowGate_reg, lowGate_next;

  // Never turn one switch on until the other is sensed off
  always_comb begin
    highGate_next = 1'b0;
    lowGate_next  = 1'b0;
    case (request)
      vcore_seq_pkg::GATE_HIGH: begin
        highGate_next = !lowGate_reg && lowOffSense;
      end
      vcore_seq_pkg::GATE_LOW: begin
        lowGate_next = !highGate_reg && highOffSense;
      end
      default: begin
        highGate_next = 1'b0;
        lowGate_next  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      highGate_reg <= 1'b0;
      lowGate_reg  <= 1'b0;
    end else begin
      highGate_reg <= highGate_next;
      lowGate_reg  <= lowGate_next;
    end
  end

  assign highGate = highGate_reg;
  assign lowGate  = lowGate_reg;
endmodule : dead_time_phase

/* File: verilog/vcore_sequencer_fault_latch.sv */
// Power sequencer and latched fault logic for a 3/2-phase core regulator.
// Assumes analog comparators arrive as digital levels from another domain.
`timescale 1ns/100ps
module vcore_sequencer_fault_latch #(
  parameter int unsigned MASK_CYC        = vcore_seq_pkg::MASK_CYC,
  parameter int unsigned CLOCK_ENABLE_N_OUT_DELAY_CYC = vcore_seq_pkg::CLOCK_ENABLE_N_OUT_DELAY_CYC,
  parameter int unsigned PGOOD_DELAY_CYC = vcore_seq_pkg::PGOOD_DELAY_CYC,
  parameter int unsigned SLEW_STEP_CYC   = vcore_seq_pkg::SLEW_STEP_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // System control pins
  input  wire logic        shutdown_n_in,
  input  wire logic        testModeLevel,
  input  wire logic        deep_sleep_request,
  input  wire logic        phase_count_n_in,
  input  wire logic [7:0]  voltage_id_code,
  // Analog comparator levels
  input  wire logic        supplyAbovePor,
  input  wire logic        supplyAboveUvlo,
  input  wire logic        refAboveUvlo,
  input  wire logic        outAtTarget,
  input  wire logic        outBelowFloor,
  input  wire logic        overVoltTrack,
  input  wire logic        overVoltFixed,
  input  wire logic        underVolt,
  input  wire logic        overTemp,
  input  wire logic        tempCooled,
  // Gate-off sense, phases 1 and 2
  input  wire logic [1:0]  highOffSense,
  input  wire logic [1:0]  lowOffSense,
  // Phase PWM request from the control loop
  input  wire logic [1:0]  pwmHigh,
  input  wire logic        phase3Pwm,
  // Outputs
  output logic             high_side_gate_1,
  output logic             high_side_gate_2,
  output logic             low_side_gate_1,
  output logic             low_side_gate_2,
  output logic             phase3_pwm_out,
  output logic             phase3PwmOe,
  output logic             phase3_skip_n_out,
  output logic             clock_enable_n_out,
  output logic             power_good_od_o,
  output logic             power_good_od_oe,
  output logic             output_discharge_node,
  output logic             referenceEnable,
  output logic             skipMode,
  output logic [7:0]       targetCode,
  output logic             faultLatched
);
  localparam int NSYNC = 11;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [NSYNC-1:0] rawIn;
  logic [NSYNC-1:0] syncA, syncB, syncC;
  logic [NSYNC-1:0] filt_reg, filt_next;
  assign rawIn = {shutdown_n_in, testModeLevel, supplyAbovePor, supplyAboveUvlo,
                  refAboveUvlo, outAtTarget, outBelowFloor, overVoltTrack,
                  overVoltFixed, underVolt, overTemp};

  // Change accepted once the second and third stages agree
  always_comb begin
    for (int i = 0; i < NSYNC; i++) begin
      filt_next[i] = (syncB[i] == syncC[i]) ? syncC[i] : filt_reg[i];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      syncA    <= '0;
      syncB    <= '0;
      syncC    <= '0;
      filt_reg <= '0;
    end else begin
      syncA    <= rawIn;
      syncB    <= syncA;
      syncC    <= syncB;
      filt_reg <= filt_next;
    end
  end

  logic shdnN, testMode, porOk, uvloOk, refOk, atTarget, atFloor;
  logic ovTrack, ovFixed, uvSense, hotSense;
  assign {shdnN, testMode, porOk, uvloOk, refOk, atTarget, atFloor,
          ovTrack, ovFixed, uvSense, hotSense} = filt_reg;

  // Cooling sense is slow and only gates clearing; plain three-stage path
  logic [2:0] coolSync;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      coolSync <= 3'h0;
    end else begin
      coolSync <= {coolSync[1:0], tempCooled};
    end
  end

  // ------------------------------------------------------------
  // Sequencer, timer, target ramp and fault latch
  // ------------------------------------------------------------
  vcore_seq_pkg::seq_state_t state_reg, state_next;
  logic [22:0] timer_reg, timer_next;
  logic [7:0]  target_reg, target_next;
  logic [7:0]  slewCnt_reg, slewCnt_next;
  logic        fault_reg, fault_next;
  logic        hot_reg, hot_next;
  logic        shdnPrev_reg;
  logic        clock_enable_n_out_reg, clock_enable_n_out_next;
  logic        pgood_reg, pgood_next;
  logic        inReg_reg, inReg_next;
  logic        downTrans_reg, downTrans_next;
  logic        slewTick, softPhase, ovFault, uvFault, thermFault;

  // Quarter-rate during soft-start and soft shutdown
  assign softPhase = (state_reg == vcore_seq_pkg::ST_SOFT) ||
                     (state_reg == vcore_seq_pkg::ST_SHUT);
  assign slewTick = (slewCnt_reg == 8'h00);

  // Skip mode in soft-start or when sleeping; forced PWM in shutdown
  logic skipNow;
  assign skipNow = (state_reg == vcore_seq_pkg::ST_SOFT) ||
                   (state_reg != vcore_seq_pkg::ST_SHUT && deep_sleep_request);

  // Threshold choice: in skip mode, fixed level until regulating or on a down transition
  always_comb begin
    if (skipNow && (!inReg_reg || downTrans_reg)) begin
      ovFault = ovFixed;
    end else begin
      ovFault = ovTrack;
    end
    ovFault    = ovFault && !testMode && (state_reg != vcore_seq_pkg::ST_OFF);
    uvFault    = uvSense && !testMode && (state_reg == vcore_seq_pkg::ST_RUN);
    thermFault = hotSense && !testMode;
  end

  always_comb begin
    state_next     = state_reg;
    timer_next     = (timer_reg != 23'h0) ? timer_reg - 23'h1 : timer_reg;
    target_next    = target_reg;
    slewCnt_next   = slewTick ? 8'(softPhase ? SLEW_STEP_CYC * vcore_seq_pkg::SOFT_DIV - 1
                                               : SLEW_STEP_CYC - 1)
                              : slewCnt_reg - 8'h01;
    fault_next     = fault_reg;
    hot_next       = hot_reg || thermFault;
    clock_enable_n_out_next     = clock_enable_n_out_reg;
    pgood_next     = pgood_reg;
    inReg_next     = skipNow ? (inReg_reg || atTarget) : 1'b0;
    downTrans_next = (state_reg == vcore_seq_pkg::ST_RUN) && (voltage_id_code < target_reg);
    // Fault set wins over the shutdown-toggle clear; test mode masks every fault so its clear always takes; reset or power-on reset still clears it
    if (ovFault || uvFault || thermFault) begin
      fault_next = 1'b1;
    end else if (testMode || (shdnN && !shdnPrev_reg && (!hot_reg || coolSync[2]))) begin
      fault_next = 1'b0;
      hot_next   = 1'b0;
    end
    case (state_reg)
      vcore_seq_pkg::ST_OFF: begin
        target_next = 8'h00;
        clock_enable_n_out_next  = 1'b1;
        pgood_next  = 1'b0;
        if (shdnN && uvloOk && !fault_reg) begin
          state_next = vcore_seq_pkg::ST_REF;
        end
      end
      vcore_seq_pkg::ST_REF: begin
        if (refOk) begin
          state_next = vcore_seq_pkg::ST_MASK;
          timer_next = 23'(MASK_CYC);
        end
      end
      vcore_seq_pkg::ST_MASK: begin
        if (timer_reg == 23'h0) begin
          state_next = vcore_seq_pkg::ST_SOFT;
        end
      end
      vcore_seq_pkg::ST_SOFT: begin
        if (target_reg >= vcore_seq_pkg::BOOT_CODE) begin
          state_next = vcore_seq_pkg::ST_BOOTWAIT;
          timer_next = 23'(CLOCK_ENABLE_N_OUT_DELAY_CYC);
        end else if (slewTick) begin
          target_next = target_reg + 8'h01;
        end
      end
      vcore_seq_pkg::ST_BOOTWAIT: begin
        if (timer_reg == 23'h0) begin
          state_next = vcore_seq_pkg::ST_RUN;
          clock_enable_n_out_next = 1'b0;
          timer_next = 23'(PGOOD_DELAY_CYC);
        end
      end
      vcore_seq_pkg::ST_RUN: begin
        if (slewTick && target_reg < voltage_id_code) begin
          target_next = target_reg + 8'h01;
        end else if (slewTick && target_reg > voltage_id_code) begin
          target_next = target_reg - 8'h01;
        end
        if (timer_reg == 23'h1) begin
          pgood_next = 1'b1;
        end
      end
      vcore_seq_pkg::ST_SHUT: begin
        if (atFloor || target_reg == 8'h00) begin
          state_next = vcore_seq_pkg::ST_DONE;
        end else if (slewTick) begin
          target_next = target_reg - 8'h01;
        end
      end
      default: begin
        if (!shdnN || !fault_reg) begin
          state_next = vcore_seq_pkg::ST_OFF;
        end
      end
    endcase
    // Shutdown request or undervoltage starts the soft ramp down
    if ((!shdnN || uvFault) && state_reg != vcore_seq_pkg::ST_OFF &&
        state_reg != vcore_seq_pkg::ST_SHUT && state_reg != vcore_seq_pkg::ST_DONE) begin
      state_next = vcore_seq_pkg::ST_SHUT;
      pgood_next = 1'b0;
    end
    if (!uvloOk || thermFault) begin
      state_next = vcore_seq_pkg::ST_OFF;
      pgood_next = 1'b0;
      clock_enable_n_out_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || !porOk) begin
      state_reg     <= vcore_seq_pkg::ST_OFF;
      timer_reg     <= 23'h0;
      target_reg    <= 8'h00;
      slewCnt_reg   <= 8'h00;
      fault_reg     <= 1'b0;
      hot_reg       <= 1'b0;
      shdnPrev_reg  <= 1'b0;
      clock_enable_n_out_reg     <= 1'b1;
      pgood_reg     <= 1'b0;
      inReg_reg     <= 1'b0;
      downTrans_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      timer_reg     <= timer_next;
      target_reg    <= target_next;
      slewCnt_reg   <= slewCnt_next;
      fault_reg     <= fault_next;
      hot_reg       <= hot_next;
      shdnPrev_reg  <= shdnN;
      clock_enable_n_out_reg     <= clock_enable_n_out_next;
      pgood_reg     <= pgood_next;
      inReg_reg     <= inReg_next;
      downTrans_reg <= downTrans_next;
    end
  end

  // ------------------------------------------------------------
  // Gate selection
  // ------------------------------------------------------------
  logic switching, multiPhase, crowbar, ovTrackLatch, ovMulti;
  assign switching = (state_reg == vcore_seq_pkg::ST_SOFT) ||
                     (state_reg == vcore_seq_pkg::ST_BOOTWAIT) ||
                     (state_reg == vcore_seq_pkg::ST_RUN) ||
                     (state_reg == vcore_seq_pkg::ST_SHUT);
  // Sleep and phase count ignored during soft-start and shutdown
  assign multiPhase = softPhase || (!deep_sleep_request && phase_count_n_in);
  // Crowbar only while switching; a stopped converter parks its drivers
  assign crowbar = fault_reg && ovTrackLatch && switching;

  // Remember an overvoltage cause so the crowbar holds while latched
  always_ff @(posedge ref_clk) begin
    if (reset || !porOk) begin
      ovTrackLatch <= 1'b0;
      ovMulti      <= 1'b0;
    end else if (ovFault && !fault_reg) begin
      ovTrackLatch <= 1'b1;
      ovMulti      <= multiPhase && !skipNow;
    end else if (!fault_reg) begin
      ovTrackLatch <= 1'b0;
    end
  end

  vcore_seq_pkg::gate_req_t req [2];
  logic [1:0] hiG, loG;
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      req[p] = vcore_seq_pkg::GATE_OFF;
      if (crowbar && (p == 0 || ovMulti)) begin
        req[p] = vcore_seq_pkg::GATE_LOW;
      end else if (!fault_reg && switching && (p == 0 || (!skipNow && !deep_sleep_request) ||
                   softPhase)) begin
        req[p] = pwmHigh[p] ? vcore_seq_pkg::GATE_HIGH : vcore_seq_pkg::GATE_LOW;
      end
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_phase
      dead_time_phase u_phase (
        .ref_clk      (ref_clk),
        .reset        (reset),
        .request      (req[gp]),
        .highOffSense (highOffSense[gp]),
        .lowOffSense  (lowOffSense[gp]),
        .highGate     (hiG[gp]),
        .lowGate      (loG[gp])
      );
    end
  endgenerate

  // Phase 3 via external driver
  logic p3Pwm_reg, p3Oe_reg, p3Skip_reg, disch_reg;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      p3Pwm_reg  <= 1'b0;
      p3Oe_reg   <= 1'b0;
      p3Skip_reg <= 1'b0;
      disch_reg  <= 1'b1;
    end else if (crowbar && ovMulti) begin
      p3Pwm_reg  <= 1'b0;
      p3Oe_reg   <= 1'b1;
      p3Skip_reg <= 1'b1;
      disch_reg  <= 1'b0;
    end else if (!fault_reg && switching && multiPhase && !skipNow) begin
      p3Pwm_reg  <= phase3Pwm;
      p3Oe_reg   <= 1'b1;
      p3Skip_reg <= 1'b1;
      disch_reg  <= 1'b0;
    end else begin
      p3Pwm_reg  <= 1'b0;
      p3Oe_reg   <= 1'b0;
      p3Skip_reg <= 1'b0;
      disch_reg  <= !switching && !crowbar;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  logic skip_reg, refEn_reg;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      skip_reg  <= 1'b0;
      refEn_reg <= 1'b0;
    end else begin
      skip_reg  <= skipNow && switching;
      refEn_reg <= (state_reg != vcore_seq_pkg::ST_OFF) &&
                   (state_reg != vcore_seq_pkg::ST_DONE);
    end
  end

  assign high_side_gate_1      = hiG[0];
  assign high_side_gate_2      = hiG[1];
  assign low_side_gate_1       = loG[0];
  assign low_side_gate_2       = loG[1];
  assign phase3_pwm_out        = p3Pwm_reg;
  assign phase3PwmOe           = p3Oe_reg;
  assign phase3_skip_n_out     = p3Skip_reg;
  assign clock_enable_n_out    = clock_enable_n_out_reg;
  assign power_good_od_o       = 1'b0;
  assign power_good_od_oe      = !pgood_reg;
  assign output_discharge_node = disch_reg;
  assign referenceEnable       = refEn_reg;
  assign skipMode              = skip_reg;
  assign targetCode            = target_reg;
  assign faultLatched          = fault_reg;
endmodule : vcore_sequencer_fault_latch

/* File: verification/vcore_seq_monitor.sv */
// Port-level assertions for the core-voltage sequencer and fault latch.
// Assumes a bind to vcore_sequencer_fault_latch; one clock, sync reset.
`timescale 1ns/100ps
module vcore_seq_monitor #(
  parameter int unsigned PGOOD_DELAY_CYC = 20
) (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       reset,
  // Inputs watched
  input wire logic       shutdown_n_in,
  input wire logic       testModeLevel,
  input wire logic       deep_sleep_request,
  input wire logic       phase_count_n_in,
  input wire logic       supplyAbovePor,
  input wire logic       supplyAboveUvlo,
  input wire logic       overVoltTrack,
  input wire logic       overTemp,
  // Outputs watched
  input wire logic       high_side_gate_1,
  input wire logic       high_side_gate_2,
  input wire logic       low_side_gate_1,
  input wire logic       low_side_gate_2,
  input wire logic       phase3_pwm_out,
  input wire logic       phase3PwmOe,
  input wire logic       phase3_skip_n_out,
  input wire logic       clock_enable_n_out,
  input wire logic       power_good_od_oe,
  input wire logic       output_discharge_node,
  input wire logic       referenceEnable,
  input wire logic [7:0] targetCode,
  input wire logic       faultLatched
);
  logic [31:0] pgCnt_reg;
  logic [31:0] pgCnt_next;
  logic        gatesOff;
  logic        parked;

  // Cycles since clock-enable went low
  always_comb begin
    pgCnt_next = clock_enable_n_out ? 32'h0 : pgCnt_reg + 32'h1;
  end
  always_ff @(posedge ref_clk) begin
    pgCnt_reg <= reset ? 32'h0 : pgCnt_next;
  end
  assign gatesOff = !high_side_gate_1 && !high_side_gate_2 && !low_side_gate_1 && !low_side_gate_2;
  assign parked = gatesOff && !phase3PwmOe && !phase3_skip_n_out && output_discharge_node;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  chk_no_shoot_thru: assert property (
    !(high_side_gate_1 && low_side_gate_1) && !(high_side_gate_2 && low_side_gate_2))
    else $error("Both gates of one phase on");
  chk_uvlo_stop: assert property (
    !supplyAboveUvlo [*8] |-> gatesOff && output_discharge_node)
    else $error("Gates active below lockout");
  chk_shutdown_n_in_pgood: assert property (
    !shutdown_n_in [*8] |-> power_good_od_oe)
    else $error("Power good released while shut down");
  chk_pgood_delay: assert property (
    $fell(power_good_od_oe) |-> pgCnt_reg >= PGOOD_DELAY_CYC - 1
      && pgCnt_reg <= PGOOD_DELAY_CYC + 2)
    else $error("Power good release delay wrong");
  chk_clock_enable_n_out_boot: assert property (
    $fell(clock_enable_n_out) |-> $past(targetCode) == vcore_seq_pkg::BOOT_CODE)
    else $error("Clock enable before boot level");
  chk_slew_step: assert property (
    $changed(targetCode) && referenceEnable && $past(referenceEnable)
      |-> targetCode == $past(targetCode) + 8'h01 || targetCode == $past(targetCode) - 8'h01)
    else $error("Target moved by more than one step");
  chk_ov_crowbar: assert property (
    $rose(faultLatched) && overVoltTrack && !deep_sleep_request && phase_count_n_in
      |-> ##[1:8] low_side_gate_1 && low_side_gate_2 && !high_side_gate_1
      && !high_side_gate_2 && !phase3_pwm_out && phase3PwmOe && phase3_skip_n_out)
    else $error("Multiphase crowbar pattern missing");
  chk_therm_park: assert property (
    $rose(faultLatched) && overTemp && !overVoltTrack |-> ##[1:8] parked)
    else $error("Thermal fault did not park outputs");
  chk_test_clear: assert property (
    testModeLevel [*8] |-> !faultLatched)
    else $error("Latch set in test mode");
  chk_por_clear: assert property (
    !supplyAbovePor [*8] |-> !faultLatched)
    else $error("Latch survives power-on reset");
endmodule : vcore_seq_monitor

bind vcore_sequencer_fault_latch vcore_seq_monitor #(.PGOOD_DELAY_CYC(PGOOD_DELAY_CYC)) i_mon (
  .ref_clk, .reset, .shutdown_n_in, .testModeLevel, .deep_sleep_request, .phase_count_n_in,
  .supplyAbovePor, .supplyAboveUvlo, .overVoltTrack, .overTemp, .high_side_gate_1,
  .high_side_gate_2, .low_side_gate_1, .low_side_gate_2, .phase3_pwm_out, .phase3PwmOe,
  .phase3_skip_n_out, .clock_enable_n_out, .power_good_od_oe, .output_discharge_node,
  .referenceEnable, .targetCode, .faultLatched);

/* File: verification/pm_host_model.sv */
// System-side model: shutdown pin, test level, gate sensing, output levels.
// Assumes bench requests change at the falling edge of ref_clk.
`timescale 1ns/100ps
module pm_host_model (
  // Clock
  input  wire logic       ref_clk,
  // Bench requests
  input  wire logic       enableReq,
  input  wire logic       testReq,
  // Device outputs and voltage_id_code seen
  input  wire logic [1:0] highGates,
  input  wire logic [1:0] lowGates,
  input  wire logic       referenceEnable,
  input  wire logic [7:0] targetCode,
  input  wire logic [7:0] voltage_id_code,
  // Levels back to the device
  output logic            shutdown_n_in,
  output logic            testModeLevel,
  output logic [1:0]      highOffSense,
  output logic [1:0]      lowOffSense,
  output logic            refAboveUvlo,
  output logic            outAtTarget,
  output logic            outBelowFloor
);
  // Test level lifts the pin high too, so the toggle path stays separate
  assign shutdown_n_in = enableReq | testReq;
  assign testModeLevel = testReq;
  initial begin
    {highOffSense, lowOffSense} = 4'hf;
    {refAboveUvlo, outAtTarget, outBelowFloor} = 3'h1;
  end
  // Sense lags the gate a cycle, so a driver that skips dead time shoots through
  always @(posedge ref_clk) begin
    highOffSense <= ~highGates;
    lowOffSense <= ~lowGates;
    refAboveUvlo <= referenceEnable;
    outAtTarget <= (targetCode == voltage_id_code);
    outBelowFloor <= (targetCode == 8'h00);
  end
endmodule : pm_host_model

/* File: verification/tb_top.sv */
// Self-checking bench for the core-voltage sequencer and fault latch.
// Assumes shortened delay parameters; pm_host_model closes the loop.
`timescale 1ns/100ps
module tb_top;
  localparam int unsigned CLKD = 10;
  localparam int unsigned PGD = 20;
  localparam int unsigned SLEW = 2;
  logic ref_clk = 1'b0, reset = 1'b1, enableReq = 1'b0, testReq = 1'b0;
  logic deep_sleep_request = 1'b0, phase_count_n_in = 1'b1, supplyAbovePor = 1'b1;
  logic supplyAboveUvlo = 1'b1, overVoltTrack = 1'b0, overTemp = 1'b0, tempCooled = 1'b0;
  logic phase3Pwm = 1'b0;
  logic [1:0] pwmHigh = 2'h0;
  logic [7:0] voltage_id_code = 8'h60, lfsr = 8'h37, targetCode;
  logic [1:0] highOffSense, lowOffSense;
  logic shutdown_n_in, testModeLevel, refAboveUvlo, outAtTarget, outBelowFloor;
  logic hg1, hg2, lg1, lg2, p3, p3oe, skn, clkenN, pgOe, disch, refEn, skipMode, faultLatched;
  int errors = 0, n_tests = 0, n, cyc = 0, tCk;

  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc++;
  // Random loop requests keep the dead-time logic busy all run
  function automatic logic [7:0] lfsrNext(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsrNext
  always @(negedge ref_clk) begin
    lfsr = lfsrNext(lfsr);
    pwmHigh = lfsr[1:0];
    phase3Pwm = lfsr[2];
  end

  vcore_sequencer_fault_latch #(.MASK_CYC(10), .CLOCK_ENABLE_N_OUT_DELAY_CYC(CLKD), .PGOOD_DELAY_CYC(PGD),
    .SLEW_STEP_CYC(SLEW)) i_dut (
    .ref_clk, .reset, .shutdown_n_in, .testModeLevel, .deep_sleep_request, .phase_count_n_in,
    .voltage_id_code, .supplyAbovePor, .supplyAboveUvlo, .refAboveUvlo, .outAtTarget,
    .outBelowFloor, .overVoltTrack, .overVoltFixed(1'b0), .underVolt(1'b0), .overTemp,
    .tempCooled, .highOffSense, .lowOffSense, .pwmHigh, .phase3Pwm, .high_side_gate_1(hg1),
    .high_side_gate_2(hg2), .low_side_gate_1(lg1), .low_side_gate_2(lg2), .phase3_pwm_out(p3),
    .phase3PwmOe(p3oe), .phase3_skip_n_out(skn), .clock_enable_n_out(clkenN),
    .power_good_od_o(), .power_good_od_oe(pgOe), .output_discharge_node(disch),
    .referenceEnable(refEn), .skipMode, .targetCode, .faultLatched);
  pm_host_model i_host (.ref_clk, .enableReq, .testReq, .highGates({hg2, hg1}),
    .lowGates({lg2, lg1}), .referenceEnable(refEn), .targetCode, .voltage_id_code,
    .shutdown_n_in, .testModeLevel, .highOffSense, .lowOffSense, .refAboveUvlo, .outAtTarget,
    .outBelowFloor);

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t %s: seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic waitSig(ref logic s, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (s !== v && cnt < lim) begin
      @(negedge ref_clk);
      cnt++;
    end
    if (s !== v) begin
      errors++;
      $display("BAD %0t wait timed out", $time);
      end_sim();
    end
  endtask : waitSig
  task automatic waitTgt(input logic [7:0] v, input int lim, output int cnt);
    cnt = 0;
    while (targetCode !== v && cnt < lim) begin
      @(negedge ref_clk);
      cnt++;
    end
    chk(targetCode, v, "target reached");
  endtask : waitTgt
  task automatic ticks(input int k);
    repeat (k) @(negedge ref_clk);
  endtask : ticks

  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    $display("BAD %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    ticks(20);
    reset = 1'b0;
    ticks(4);
    enableReq = 1'b1;
    waitSig(refEn, 1'b1, 50, n);
    chk(refEn, 1'b1, "reference on");
    waitTgt(8'h01, 400, n);
    waitTgt(8'h02, 400, n);
    chk(n, SLEW * vcore_seq_pkg::SOFT_DIV, "soft step");
    chk(skipMode, 1'b1, "skip in soft start");
    waitTgt(vcore_seq_pkg::BOOT_CODE, 2000, n);
    waitSig(clkenN, 1'b0, 400, n);
    tCk = cyc;
    chk(n >= CLKD && n <= CLKD + 3, 1'b1, "clock enable delay");
    waitTgt(vcore_seq_pkg::BOOT_CODE + 8'h01, 50, n);
    waitTgt(vcore_seq_pkg::BOOT_CODE + 8'h02, 50, n);
    chk(n, SLEW, "full rate step");
    waitSig(pgOe, 1'b0, PGD + 50, n);
    chk(cyc - tCk >= PGD && cyc - tCk <= PGD + 3, 1'b1, "power good delay");
    $display("Test power-up done");
    phase_count_n_in = 1'b0;
    ticks(8);
    chk({p3oe, skn}, 2'b00, "phase 3 off");
    deep_sleep_request = 1'b1;
    phase_count_n_in = 1'b1;
    ticks(8);
    chk({hg2, lg2, p3oe, skn, skipMode}, 5'b00001, "single phase skip");
    deep_sleep_request = 1'b0;
    ticks(8);
    overVoltTrack = 1'b1;
    waitSig(faultLatched, 1'b1, 20, n);
    ticks(10);
    chk({lg1, lg2, hg1, hg2, p3, p3oe, skn}, 7'b1100011, "multiphase crowbar");
    overVoltTrack = 1'b0;
    ticks(30);
    chk(faultLatched, 1'b1, "latch holds");
    enableReq = 1'b0;
    ticks(8);
    chk(pgOe, 1'b1, "power good pulled low");
    waitSig(refEn, 1'b0, 1500, n);
    chk({hg1, hg2, lg1, lg2, p3oe, skn, disch}, 7'b0000001, "parked");
    enableReq = 1'b1;
    ticks(8);
    chk(faultLatched, 1'b0, "toggle clears");
    $display("Test overvoltage and shutdown done");
    waitSig(clkenN, 1'b0, 3000, n);
    deep_sleep_request = 1'b1;
    ticks(40);
    overVoltTrack = 1'b1;
    waitSig(faultLatched, 1'b1, 20, n);
    ticks(10);
    chk({lg1, hg1, lg2, hg2}, 4'b1000, "single phase crowbar");
    testReq = 1'b1;
    ticks(10);
    chk(faultLatched, 1'b0, "test mode clears");
    ticks(20);
    chk(faultLatched, 1'b0, "test mode masks faults");
    {overVoltTrack, testReq, deep_sleep_request} = 3'b000;
    $display("Test single phase and test mode done");
    ticks(8);
    overTemp = 1'b1;
    waitSig(faultLatched, 1'b1, 20, n);
    ticks(8);
    chk({hg1, hg2, lg1, lg2, p3oe, skn, disch}, 7'b0000001, "thermal park");
    overTemp = 1'b0;
    enableReq = 1'b0;
    ticks(12);
    enableReq = 1'b1;
    ticks(12);
    chk(faultLatched, 1'b1, "latch needs cooling");
    supplyAbovePor = 1'b0;
    ticks(10);
    chk(faultLatched, 1'b0, "power-on reset clears");
    supplyAbovePor = 1'b1;
    $display("Test thermal and power-on reset done");
    waitSig(clkenN, 1'b0, 3000, n);
    supplyAboveUvlo = 1'b0;
    ticks(8);
    chk({hg1, hg2, lg1, lg2, disch}, 5'b00001, "lockout stop");
    ticks(20);
    chk(refEn, 1'b0, "no reference below lockout");
    $display("Test lockout done");
    end_sim();
  end
endmodule : tb_top
